// ==== rtl/jtid_defines.vh ====
// constants for the test access port instruction decoder
`ifndef JTID_DEFINES_VH
`define JTID_DEFINES_VH
// instruction width and codes
`define JTID_IR_W 3
`define JTID_OP_EXTEST 3'h0
`define JTID_OP_IDCODE 3'h1
`define JTID_OP_SAMPZ 3'h2
`define JTID_OP_SAMPLE 3'h4
`define JTID_OP_BYPASS 3'h7
// capture pattern for the two low instruction bits
`define JTID_IR_CAP 2'h1
// reset levels of the pin synchronisers
`define JTID_SYNC_LO 2'h0
`define JTID_SYNC_HI 2'h3
// identification register width
`define JTID_ID_W 32
// tap controller states
`define JTID_S_TLR 4'h0
`define JTID_S_RTI 4'h1
`define JTID_S_SELDR 4'h2
`define JTID_S_CAPDR 4'h3
`define JTID_S_SHDR 4'h4
`define JTID_S_EX1DR 4'h5
`define JTID_S_PSDR 4'h6
`define JTID_S_EX2DR 4'h7
`define JTID_S_UPDR 4'h8
`define JTID_S_SELIR 4'h9
`define JTID_S_CAPIR 4'ha
`define JTID_S_SHIR 4'hb
`define JTID_S_EX1IR 4'hc
`define JTID_S_PSIR 4'hd
`define JTID_S_EX2IR 4'he
`define JTID_S_UPIR 4'hf
`endif

// ==== rtl/jtid_tap.v ====
// test access port with instruction decode and data register select
`timescale 1ns/1ps
// How it works
// - code 000 selects boundary scan path
// - code 001 captures and shifts identification
// - code 010 samples ring, outputs high impedance
// - code 100 samples ring, outputs normal
// - code 111 selects one-bit bypass
// - reset loads default instruction
// - codes read binary, msb left
// - three-bit instruction, default identification
// - capture loads 01; update applies instruction
// - 32-bit identification, lsb shifted first
`include "jtid_defines.vh"
module jtid_tap #(
    parameter BSR_W = 8,             // boundary scan length
    parameter [31:0] ID_CODE = 32'h00000001 // arbitrary value
) (
    // clock and control
    clk,
    sys_rst,
    clk_en,
    // jtag pins (asynchronous to clk)
    tck,
    tms,
    tdi,
    tdo,
    tdo_oe_n,
    // i/o ring
    ring_in,
    ring_out,
    ring_drive,
    ram_hiz,
    cur_ir
);
    input wire clk;
    input wire sys_rst;
    input wire clk_en;
    input wire tck;
    input wire tms;
    input wire tdi;
    output reg tdo;
    output reg tdo_oe_n;
    input wire [BSR_W-1:0] ring_in;
    output reg [BSR_W-1:0] ring_out;
    output reg ring_drive;
    output reg ram_hiz;
    output reg [`JTID_IR_W-1:0] cur_ir;

    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    reg [1:0] tck_s_reg; // tck sync stages
    reg [1:0] tms_s_reg; // tms sync stages
    reg [1:0] tdi_s_reg; // tdi sync stages
    reg tck_d_reg; // delayed synced tck
    reg [BSR_W-1:0] ring_s0_reg; // i/o ring first sync stage
    reg [BSR_W-1:0] ring_s1_reg; // i/o ring second sync stage
    // edges of the synced tck, seen one clock after the second stage
    wire tck_rise = tck_s_reg[1] & ~tck_d_reg;
    wire tck_fall = ~tck_s_reg[1] & tck_d_reg;

    // -----------------------------------------------------------
    // tap state and registers
    // -----------------------------------------------------------
    reg [3:0] st_reg; // controller state
    reg [3:0] st_next; // next controller state
    reg [`JTID_IR_W-1:0] irsh_reg; // instruction shift stage
    reg [`JTID_ID_W-1:0] id_reg; // identification shifter
    reg [BSR_W-1:0] bsr_reg; // boundary scan shifter
    reg byp_reg; // bypass bit
    reg so_reg; // serial out, launched on falling tck

    // classify instruction as boundary scan user
    function is_bsr;
        input [`JTID_IR_W-1:0] op;
        begin
            is_bsr = (op == `JTID_OP_EXTEST) |
                     (op == `JTID_OP_SAMPZ) |
                     (op == `JTID_OP_SAMPLE);
        end
    endfunction

    // next state from tms
    always @* begin
        st_next = st_reg;
        case (st_reg)
            `JTID_S_TLR: st_next = tms_s_reg[1] ? `JTID_S_TLR : `JTID_S_RTI;
            `JTID_S_RTI: st_next = tms_s_reg[1] ? `JTID_S_SELDR : `JTID_S_RTI;
            `JTID_S_SELDR: st_next = tms_s_reg[1] ? `JTID_S_SELIR
                                                   : `JTID_S_CAPDR;
            `JTID_S_CAPDR: st_next = tms_s_reg[1] ? `JTID_S_EX1DR
                                                   : `JTID_S_SHDR;
            `JTID_S_SHDR: st_next = tms_s_reg[1] ? `JTID_S_EX1DR
                                                   : `JTID_S_SHDR;
            `JTID_S_EX1DR: st_next = tms_s_reg[1] ? `JTID_S_UPDR
                                                   : `JTID_S_PSDR;
            `JTID_S_PSDR: st_next = tms_s_reg[1] ? `JTID_S_EX2DR
                                                   : `JTID_S_PSDR;
            `JTID_S_EX2DR: st_next = tms_s_reg[1] ? `JTID_S_UPDR
                                                   : `JTID_S_SHDR;
            `JTID_S_UPDR: st_next = tms_s_reg[1] ? `JTID_S_SELDR : `JTID_S_RTI;
            `JTID_S_SELIR: st_next = tms_s_reg[1] ? `JTID_S_TLR
                                                   : `JTID_S_CAPIR;
            `JTID_S_CAPIR: st_next = tms_s_reg[1] ? `JTID_S_EX1IR
                                                   : `JTID_S_SHIR;
            `JTID_S_SHIR: st_next = tms_s_reg[1] ? `JTID_S_EX1IR
                                                   : `JTID_S_SHIR;
            `JTID_S_EX1IR: st_next = tms_s_reg[1] ? `JTID_S_UPIR
                                                   : `JTID_S_PSIR;
            `JTID_S_PSIR: st_next = tms_s_reg[1] ? `JTID_S_EX2IR
                                                   : `JTID_S_PSIR;
            `JTID_S_EX2IR: st_next = tms_s_reg[1] ? `JTID_S_UPIR
                                                   : `JTID_S_SHIR;
            `JTID_S_UPIR: st_next = tms_s_reg[1] ? `JTID_S_SELDR : `JTID_S_RTI;
            default: st_next = `JTID_S_TLR;
        endcase
    end

    // -----------------------------------------------------------
    // sampling, rising-edge and falling-edge work
    // -----------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            tck_s_reg <= `JTID_SYNC_LO;
            tms_s_reg <= `JTID_SYNC_HI; // tms idles high
            tdi_s_reg <= `JTID_SYNC_LO;
            tck_d_reg <= 1'b0;
            ring_s0_reg <= {BSR_W{1'b0}};
            ring_s1_reg <= {BSR_W{1'b0}};
            st_reg <= `JTID_S_TLR;
            irsh_reg <= `JTID_OP_IDCODE;
            cur_ir <= `JTID_OP_IDCODE;
            id_reg <= {`JTID_ID_W{1'b0}};
            bsr_reg <= {BSR_W{1'b0}};
            byp_reg <= 1'b0;
            so_reg <= 1'b0;
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
            ring_out <= {BSR_W{1'b0}};
            ring_drive <= 1'b0;
            ram_hiz <= 1'b0;
        end else if (clk_en) begin
            tck_s_reg <= {tck_s_reg[0], tck};
            tms_s_reg <= {tms_s_reg[0], tms};
            tdi_s_reg <= {tdi_s_reg[0], tdi};
            tck_d_reg <= tck_s_reg[1];
            // ring sampled twice; a word caught mid-change may be mixed
            ring_s0_reg <= ring_in;
            ring_s1_reg <= ring_s0_reg;
            // outputs follow the decoded instruction
            // both lag cur_ir by one clock
            ram_hiz <= (cur_ir == `JTID_OP_SAMPZ);
            ring_drive <= (cur_ir == `JTID_OP_EXTEST);
            if (tck_rise) begin
                st_reg <= st_next;
                case (st_reg)
                    // default instruction in reset state
                    `JTID_S_TLR: begin
                        cur_ir <= `JTID_OP_IDCODE;
                    end
                    // capture fixed pattern in low bits
                    `JTID_S_CAPIR: begin
                        irsh_reg <= {irsh_reg[`JTID_IR_W-1:2],
                                     `JTID_IR_CAP};
                    end
                    // tdi enters msb, lsb leaves first
                    `JTID_S_SHIR: begin
                        irsh_reg <= {tdi_s_reg[1],
                                     irsh_reg[`JTID_IR_W-1:1]};
                    end
                    // shifted instruction takes effect only here
                    `JTID_S_UPIR: begin
                        cur_ir <= irsh_reg;
                    end
                    // load selected data register
                    `JTID_S_CAPDR: begin
                        if (cur_ir == `JTID_OP_IDCODE)
                            id_reg <= ID_CODE;
                        else if (is_bsr(cur_ir))
                            bsr_reg <= ring_s1_reg;
                        else
                            byp_reg <= 1'b0;
                    end
                    // shift selected data register
                    `JTID_S_SHDR: begin
                        if (cur_ir == `JTID_OP_IDCODE)
                            id_reg <= {tdi_s_reg[1],
                                       id_reg[`JTID_ID_W-1:1]};
                        else if (is_bsr(cur_ir))
                            bsr_reg <= {tdi_s_reg[1],
                                        bsr_reg[BSR_W-1:1]};
                        else
                            byp_reg <= tdi_s_reg[1];
                    end
                    default: begin
                    end
                endcase
            end
            // falling tck work: serial out, enable, extest update
            if (tck_fall) begin
                // launch tdo on falling edge while shifting
                tdo_oe_n <= ~((st_reg == `JTID_S_SHDR) |
                              (st_reg == `JTID_S_SHIR));
                if (st_reg == `JTID_S_SHIR)
                    so_reg <= irsh_reg[0];
                else if (cur_ir == `JTID_OP_IDCODE)
                    so_reg <= id_reg[0];
                else if (is_bsr(cur_ir))
                    so_reg <= bsr_reg[0];
                else
                    so_reg <= byp_reg;
                // extest drives pins from scan data on update
                if (st_reg == `JTID_S_UPDR &&
                    cur_ir == `JTID_OP_EXTEST)
                    ring_out <= bsr_reg;
            end
            // extra stage keeps tdo a plain flop output
            tdo <= so_reg;
        end
    end
endmodule // jtid_tap

// ==== verif/jtid_tap_asserts.sv ====
// port assertions for the tap decoder
`timescale 1ns/1ps
module jtid_tap_asserts #(
    parameter BSR_W = 8 // boundary scan length
) (
    // clock, reset, controls
    clk,
    sys_rst,
    clk_en,
    tck,
    // observed outputs
    tdo,
    tdo_oe_n,
    ring_out,
    ring_drive,
    ram_hiz,
    cur_ir
);
    input wire clk;
    input wire sys_rst;
    input wire clk_en;
    input wire tck;
    input wire tdo;
    input wire tdo_oe_n;
    input wire [BSR_W-1:0] ring_out;
    input wire ring_drive;
    input wire ram_hiz;
    input wire [2:0] cur_ir;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst || !clk_en);
    // state forced by reset
    sequence rst_s;
        cur_ir == 3'h1 && !ram_hiz && !ring_drive && tdo_oe_n;
    endsequence
    rst_vals_a: assert property (
        disable iff (1'b0) sys_rst |=> rst_s) else $error("bad reset");
    hiz_code_a: assert property (
        ram_hiz == ($past(cur_ir) == 3'h2)) else $error("bad hiz");
    drv_code_a: assert property (
        ring_drive == ($past(cur_ir) == 3'h0)) else $error("bad drive");
    ir_shift_a: assert property (
        !tdo_oe_n |-> $stable(cur_ir)) else $error("ir moved in shift");
    ir_rise_a: assert property (
        !$stable(cur_ir) |-> tck) else $error("ir moved off rise");
    // tck pin fell between five and four clocks back
    sequence tck_fell_s;
        $past(tck, 5) && !$past(tck, 4);
    endsequence
    tdo_fall_a: assert property (
        !$stable(tdo) |-> tck_fell_s) else $error("bad tdo");
    oe_fall_a: assert property (
        !$stable(tdo_oe_n) |-> !tck) else $error("bad oe");
    ring_upd_a: assert property (
        !$stable(ring_out) |-> ring_drive && !tck) else $error("bad ring");
endmodule // jtid_tap_asserts

// ==== verif/jtid_host.sv ====
// jtag controller model walking the tap
`timescale 1ns/1ps
module jtid_host (
    // jtag pins
    tck, tms, tdi, tdo
);
    output reg tck;
    output reg tms;
    output reg tdi;
    input wire tdo;
    // one tck cycle: tdo taken before the fall
    task step(input m, input d, output q);
        begin
            tms = m;
            tdi = d;
            #160 tck = 1'b1;
            #150 q = tdo;
            #10 tck = 1'b0;
        end
    endtask
    // idle to shift, n bits lsb first, back to idle
    task scan(input ir, input integer n, input [31:0] din,
        output [31:0] dout);
        integer i;
        reg q;
        begin
            step(1'b1, ~tdi, q);
            if (ir) step(1'b1, ~tdi, q);
            step(1'b0, ~tdi, q);
            step(1'b0, ~tdi, q);
            dout = 32'h0;
            for (i = 0; i < n; i = i + 1) begin
                step(i == n - 1, din[i], q);
                dout[i] = q;
            end
            step(1'b1, ~tdi, q);
            step(1'b0, ~tdi, q);
        end
    endtask
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
endmodule // jtid_host

// ==== verif/test_jtag_tap_instruction_decode.sv ====
// bench for the tap instruction decoder
`timescale 1ns/1ps
module test_jtag_tap_instruction_decode;
    localparam BSR_W = 8;
    localparam [31:0] ID = 32'h00000001; // arbitrary value
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg clk_en = 1'b1; // low freezes the block
    reg [BSR_W-1:0] ring_in = 8'ha5;
    wire tck, tms, tdi, tdo, tdo_oe_n, ring_drive, ram_hiz;
    wire [BSR_W-1:0] ring_out;
    wire [2:0] cur_ir;
    wire tdo_pin = tdo_oe_n ? ~tdo : tdo; // released pin shows inverse
    integer bad_count = 0;
    integer tests_run = 0;
    integer c;
    reg [31:0] q;
    reg q1;
    // free-running 25 MHz system clock
    always #20 clk = ~clk;
    jtid_tap #(.BSR_W(BSR_W), .ID_CODE(ID)) jtid_tap_inst (.clk(clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .ring_in(ring_in),
        .ring_out(ring_out), .ring_drive(ring_drive), .ram_hiz(ram_hiz),
        .cur_ir(cur_ir));
    jtid_host jtid_host_inst (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo_pin));
    // compare and count
    task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    // print the verdict and end the run
    task stop_test;
        begin
            if (bad_count == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // reset instruction, capture pattern, id read
    task t_reset_id;
        begin
            chk("ir", 3'h1, cur_ir);
            chk("oe0", 1'b1, tdo_oe_n);
            jtid_host_inst.step(1'b0, 1'b0, q1);
            jtid_host_inst.scan(1'b1, 3, 32'h1, q);
            chk("ircap", 2'h1, q[1:0]);
            jtid_host_inst.scan(1'b0, 32, 32'h0, q);
            chk("id", ID, q);
        end
    endtask
    // every code: decode, pin effects, data path
    task t_codes;
        begin
            for (c = 0; c < 8; c = c + 1) begin
                jtid_host_inst.scan(1'b1, 3, c, q);
                chk("cur", c, cur_ir);
                chk("hiz", c == 2, ram_hiz);
                chk("drv", c == 0, ring_drive);
                @(posedge clk);
                #1 ring_in = ~ring_in;
                jtid_host_inst.scan(1'b0, BSR_W, 32'h3c, q);
                if (c == 0) chk("out", 8'h3c, ring_out);
                else if (c == 2 || c == 4) chk("cap", ring_in, q);
                else if (c == 1) chk("id8", ID[7:0], q);
                else chk("byp", 8'h78, q);
            end
        end
    endtask
    // clock enable low: pins ignored, instruction kept
    task t_freeze;
        begin
            #200 clk_en = 1'b0;
            jtid_host_inst.scan(1'b1, 3, 32'h2, q);
            clk_en = 1'b1;
            #200 chk("frz_ir", 3'h7, cur_ir);
            chk("frz_hiz", 1'b0, ram_hiz);
        end
    endtask
    // move to shift, output enabled, then tms high run reloads the default
    task t_tlr;
        begin
            jtid_host_inst.step(1'b1, 1'b0, q1);
            jtid_host_inst.step(1'b0, 1'b0, q1);
            jtid_host_inst.step(1'b0, 1'b0, q1);
            #200 chk("oe", 1'b0, tdo_oe_n);
            repeat (6) jtid_host_inst.step(1'b1, 1'b0, q1);
            chk("tlr", 3'h1, cur_ir);
            chk("oe_off", 1'b1, tdo_oe_n);
        end
    endtask
    // scenarios in order, then the verdict
    initial begin
        repeat (20) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_reset_id;
        t_codes;
        t_freeze;
        t_tlr;
        stop_test;
    end
    // watchdog: a hang ends as a failure
    initial begin
        #200000;
        bad_count = bad_count + 1;
        stop_test;
    end
endmodule // test_jtag_tap_instruction_decode
bind jtid_tap jtid_tap_asserts #(.BSR_W(BSR_W)) jtid_tap_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .ring_out(ring_out), .ring_drive(ring_drive),
    .ram_hiz(ram_hiz), .cur_ir(cur_ir));
